/* sim/lcd_decoder_properties.sv */
/*
 Concurrent checks on the LCD command decoder's ports.
 Assumes core_clk and the asynchronous active-high reset rst.
*/
`timescale 1ns/1ns
module lcd_decoder_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmdOrPixelSel,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [7:0] dataIn,
    input wire logic serial3Line,
    input wire logic [7:0] readData,
    input wire logic readValid,
    input wire logic columnMirror,
    input wire logic rowFlip,
    input wire logic sleepBit,
    input wire logic analogEnable,
    input lcd_cmd_pkg::cmd_page_type cmdPageSel,
    input wire logic normalShowBit,
    input wire logic litFlag,
    input lcd_cmd_pkg::show_mode_type displayMode,
    input wire logic msbTop,
    input wire logic partialEnable,
    input wire logic windowHeight,
    input lcd_cmd_pkg::duty_type dutySel,
    input wire logic [6:0] driveVoltageCode,
    input wire logic [6:0] columnPtr,
    input wire logic [3:0] pagePtr,
    input wire logic rmwActive
);
    import lcd_cmd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic rdOnly, wrCmd, wrData;
    // Write wins when both strobes are high
    assign rdOnly = readStrobe && !writeStrobe;
    assign wrCmd = writeStrobe && !cmdOrPixelSel;
    assign wrData = writeStrobe && cmdOrPixelSel;

    chk_func_set: assert property (wrCmd && dataIn[7:5] == 3'h1 |=>
        {columnMirror, rowFlip, sleepBit, cmdPageSel} == $past(dataIn[4:0])) else $error("function set not loaded");
    chk_status_byte: assert property (rdOnly && !cmdOrPixelSel |=> readValid && readData ==
        {$past(sleepBit), 2'h0, $past(normalShowBit), $past(litFlag), $past(columnMirror), $past(rowFlip),
        $past(msbTop)}) else $error("status byte wrong");
    chk_read_answer: assert property (rdOnly && cmdOrPixelSel |=> readValid)
        else $error("data read not answered");
    chk_valid_cause: assert property (readValid |-> $past(rdOnly) || $past(wrCmd && serial3Line &&
        cmdPageSel == PAGE_SYSTEM && dataIn inside {[8'hda:8'hdd]})) else $error("unrequested answer");
    chk_col_advance: assert property (wrData && columnPtr <= 7'h65 |=> columnPtr ==
        (($past(columnPtr) == 7'h65) ? 7'h00 : $past(columnPtr) + 7'h01)) else $error("column not advanced");
    chk_rmw_hold: assert property (rdOnly && cmdOrPixelSel && rmwActive |=>
        columnPtr == $past(columnPtr) && pagePtr == $past(pagePtr)) else $error("read moved address in rmw");
    chk_sleep_analog: assert property (analogEnable != sleepBit)
        else $error("analog enable wrong");
    chk_mode_code: assert property (displayMode == {litFlag, normalShowBit})
        else $error("display mode encoding wrong");
    chk_duty_map: assert property (dutySel == (partialEnable ? (windowHeight ? DUTY_PART_33 : DUTY_PART_17)
        : DUTY_FULL_68)) else $error("duty selection wrong");
    chk_idle_hold: assert property (!writeStrobe && !readStrobe |=> $stable(driveVoltageCode)
        && $stable(columnPtr) && $stable(pagePtr) && $stable(cmdPageSel)) else $error("state moved while idle");

    cover property (wrData && columnPtr == 7'h65);
    cover property (wrCmd && dataIn == 8'h06 && rmwActive);
    cover property (readValid && !$past(readStrobe));
endmodule

bind lcd_command_decoder lcd_decoder_properties chk (.*);

/* sim/lcd_host_model.sv */
/*
 Host model: one command or data byte per call.
 Assumes the decoder answers one cycle after the strobe edge.
*/
`timescale 1ns/1ns
module lcd_host_model (
    input wire logic core_clk,
    input wire logic [7:0] readData,
    input wire logic readValid,
    output logic cmdOrPixelSel,
    output logic writeStrobe,
    output logic readStrobe,
    output logic [7:0] dataIn,
    output logic serial3Line
);
    import lcd_cmd_pkg::*;
    initial begin
        cmdOrPixelSel = 1'b0;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        dataIn = 8'h00;
        serial3Line = 1'b0;
    end

    // Released data lines show the inverse, never a stale byte
    task automatic xfer(input logic sel, input logic rd, input logic [7:0] val,
                        output logic seen, output logic [7:0] got);
        @(posedge core_clk);
        cmdOrPixelSel <= sel;
        writeStrobe <= !rd;
        readStrobe <= rd;
        dataIn <= val;
        @(posedge core_clk);
        writeStrobe <= 1'b0;
        readStrobe <= 1'b0;
        dataIn <= ~val;
        #1;
        seen = readValid;
        got = readData;
    endtask

    // Out-of-range columns are never sent
    task automatic setColumn(input logic [6:0] c);
        logic s;
        logic [7:0] g;
        if (c <= LAST_COL) begin
            xfer(1'b0, 1'b0, {1'b1, c}, s, g);
        end
    endtask

    task automatic setSerial(input logic on);
        @(posedge core_clk);
        serial3Line <= on;
    endtask
endmodule

/* sim/tb.sv */
/*
 Self-checking bench for the LCD command decoder.
 Assumes the host model drives every decoder input except core_clk and rst, which the bench drives.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errCount++; $display("[ERR] %0t mismatch", $time); end end
module tb;
    import lcd_cmd_pkg::*;
    localparam logic [7:0] IDS [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3}; // Arbitrary identification values
    logic core_clk, rst, cmdOrPixelSel, writeStrobe, readStrobe, serial3Line, readValid, v;
    logic [7:0] dataIn, readData, g;
    logic columnMirror, rowFlip, sleepBit, analogEnable, normalShowBit, litFlag, msbTop, vlcdBand;
    logic partialEnable, windowHeight, rmwActive;
    cmd_page_type cmdPageSel;
    show_mode_type displayMode;
    duty_type dutySel;
    logic [2:0] biasRatioSel, partialBandOrigin, scanRateCode;
    logic [5:0] startLine;
    logic [6:0] driveVoltageCode, columnPtr;
    logic [4:0] inversionSpan;
    logic [1:0] pumpStrength, pumpStages;
    logic [3:0] pagePtr;
    int errCount = 0;
    int nTests = 0;

    lcd_command_decoder #(.ID_BYTE1(IDS[0]), .ID_BYTE2(IDS[1]), .ID_BYTE3(IDS[2]), .ID_BYTE4(IDS[3])) dut (
        .core_clk(core_clk), .rst(rst), .cmdOrPixelSel(cmdOrPixelSel), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .dataIn(dataIn), .serial3Line(serial3Line), .readData(readData),
        .readValid(readValid), .columnMirror(columnMirror), .rowFlip(rowFlip), .sleepBit(sleepBit),
        .analogEnable(analogEnable), .cmdPageSel(cmdPageSel), .normalShowBit(normalShowBit), .litFlag(litFlag),
        .displayMode(displayMode), .msbTop(msbTop), .vlcdBand(vlcdBand), .biasRatioSel(biasRatioSel),
        .startLine(startLine), .driveVoltageCode(driveVoltageCode), .partialEnable(partialEnable),
        .windowHeight(windowHeight), .dutySel(dutySel), .partialBandOrigin(partialBandOrigin),
        .scanRateCode(scanRateCode), .inversionSpan(inversionSpan), .pumpStrength(pumpStrength),
        .pumpStages(pumpStages), .columnPtr(columnPtr), .pagePtr(pagePtr), .rmwActive(rmwActive));
    lcd_host_model host (.*);

    task automatic cmd(input logic [7:0] c);
        host.xfer(1'b0, 1'b0, c, v, g);
    endtask

    task automatic t_reset;
        `CHK({sleepBit, analogEnable, columnMirror, rowFlip}, 4'h8)
        `CHK(cmdPageSel, PAGE_BASIC)
        `CHK(displayMode, SHOW_BLANK)
        `CHK({columnPtr, pagePtr, biasRatioSel, driveVoltageCode}, 21'h0)
    endtask

    task automatic t_display;
        cmd(8'h38);
        `CHK({columnMirror, rowFlip, sleepBit, analogEnable, cmdPageSel}, 6'h34)
        for (int i = 0; i < 4; i++) begin
            cmd({5'h01, i[1], 1'b0, i[0]});
            `CHK({normalShowBit, litFlag}, {i[1], i[0]})
            `CHK(displayMode, {i[0], i[1]})
            host.xfer(1'b0, 1'b1, 8'h00, v, g);
            `CHK({v, g}, {4'h8, i[1], i[0], 3'h6})
        end
    endtask

    task automatic t_ram;
        logic [7:0] pat [3] = '{8'ha1, 8'hb2, 8'hc3};
        cmd(8'h3c);
        cmd(8'h49);
        host.setColumn(7'h64);
        for (int i = 0; i < 3; i++) begin
            host.xfer(1'b1, 1'b0, pat[i], v, g);
            `CHK({pagePtr, columnPtr}, {4'h9, (i == 0) ? 7'h65 : 7'(i - 1)})
        end
        host.setColumn(7'h64);
        for (int i = 0; i < 3; i++) begin
            host.xfer(1'b1, 1'b1, 8'h00, v, g);
            `CHK({v, g}, {1'b1, pat[i]})
        end
        host.xfer(1'b0, 1'b1, 8'h00, v, g);
        `CHK(g[7], 1'b1)
    endtask

    task automatic t_rmw;
        cmd(8'h42);
        host.setColumn(7'h05);
        cmd(8'h07);
        host.xfer(1'b1, 1'b1, 8'h00, v, g);
        `CHK({rmwActive, columnPtr}, 8'h85)
        host.xfer(1'b1, 1'b0, 8'h77, v, g);
        host.xfer(1'b1, 1'b0, 8'h88, v, g);
        `CHK(columnPtr, 7'h07)
        cmd(8'h41);
        cmd(8'h06);
        `CHK({rmwActive, columnPtr, pagePtr}, 12'h052)
        host.xfer(1'b1, 1'b1, 8'h00, v, g);
        `CHK(g, 8'h77)
    endtask

    task automatic t_pages;
        cmd(8'h05);
        `CHK(vlcdBand, 1'b1)
        cmd(8'h10);
        `CHK({columnPtr, pagePtr, displayMode}, {7'h06, 4'h2, SHOW_INVERSE})
        cmd(8'h39);
        cmd(8'h0c);
        cmd(8'h15);
        cmd(8'h41);
        `CHK({msbTop, biasRatioSel, startLine, pagePtr}, {4'hd, 6'h01, 4'h2})
        cmd(8'h7f);
        cmd(8'haa);
        `CHK({startLine, driveVoltageCode, columnPtr}, {6'h3f, 7'h2a, 7'h06})
        cmd(8'h3a);
        cmd(8'h05);
        `CHK(dutySel, DUTY_PART_17)
        cmd(8'h09);
        cmd(8'h16);
        `CHK({dutySel, partialBandOrigin}, {DUTY_PART_33, 3'h6})
        cmd(8'h04);
        `CHK(dutySel, DUTY_FULL_68)
    endtask

    task automatic t_system;
        cmd(8'h3b);
        cmd(8'h0d);
        cmd(8'h55);
        cmd(8'h9d);
        cmd(8'hc0);
        `CHK({scanRateCode, inversionSpan, pumpStrength, pumpStages}, 12'hb5d)
        cmd(8'hda);
        `CHK(v, 1'b0)
        host.setSerial(1'b1);
        for (int i = 0; i < 4; i++) begin
            cmd(8'hda + 8'(i));
            `CHK({v, g}, {1'b1, IDS[i]})
        end
        cmd(8'h03);
        `CHK({startLine, columnPtr, pagePtr, rowFlip}, 18'h0)
        `CHK({columnMirror, driveVoltageCode, biasRatioSel}, 11'h555)
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge core_clk);
        errCount++;
        $display("[ERR] %0t run did not finish", $time);
        conclude();
    end

    initial begin
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_display();
        t_ram();
        t_rmw();
        t_pages();
        t_system();
        conclude();
    end
endmodule

/* verilog/lcd_cmd_pkg.sv */
/*
 Constants, reset values and enumerations for the LCD command decoder.
 Assumes a byte-wide host front end that presents one decoded access per strobe.
*/
// Notes on behaviour
// RULE_01: Command byte 001xxxxx loads mirror, flip, sleep and the two page-select bits.
// RULE_02: Page select picks the decode page; nop, function set, status and RAM always work.
// RULE_03: Mirror reverses column-to-segment order; flip reverses common scan order.
// RULE_04: Sleep grounds LCD outputs and stops bias, voltage generator and oscillator.
// RULE_05: Sleep keeps RAM contents and still accepts RAM data writes.
// RULE_06: Command-side read returns sleep, 0, 0, normal, lit, mirror, flip, msb-top.
// RULE_07: Normal and lit bits give blank, normal, all-on or inverse display.
// RULE_08: Data-side read returns the RAM byte at the current column and page.
// RULE_09: Data-side write stores the byte and advances the column by one.
// RULE_10: Column auto-increment wraps to zero after the last column.
// RULE_11: Page 00 band command sets the voltage programming range from D0.
// RULE_12: Page 00 opens read-modify-write; reads hold address, writes advance; end closes.
// RULE_13: Page 00 display control loads normal from D2 and lit from D0.
// RULE_14: Page 00 loads the four-bit page pointer, 0 to 9, all with columns 0-101.
// RULE_15: Page 00 byte with D7 set loads the seven-bit column pointer.
// RULE_16: Page 01 sets msb-top data order and the three-bit bias ratio.
// RULE_17: Page 01 loads the six-bit start line for vertical scrolling.
// RULE_18: Page 01 byte with D7 set loads the seven-bit drive voltage code.
// RULE_19: Page 10 sets partial enable, window height and partial band origin.
// RULE_20: Page 11 has soft reset, scan rate, inversion span and pump settings.
// RULE_21: Page 11 in three-line serial mode returns identification bytes one to four.
// RULE_22: End command restores column and page saved on entering read-modify-write.
// RULE_23: Partial off gives duty 1:68; on gives 1:17 or 1:33 by window height.
// RULE_24: Soft reset clears start line, column, page and common direction only.
// RULE_25: After reset: sleep set, page 00, blank, pointers, bias, voltage zero, directions clear.
// RULE_26: Reserved codes in any page change nothing.
// RULE_27: Every field holds its value until its own command or a reset.
package lcd_cmd_pkg;
    localparam int NUM_COLS = 102;
    localparam int NUM_PAGES = 10;
    localparam int RAM_WORDS = NUM_COLS * NUM_PAGES;
    localparam logic [6:0] LAST_COL = 7'h65;
    localparam logic [3:0] LAST_PAGE = 4'h9;
    localparam logic [6:0] COL_STEP = 7'h01;

    // Fixed command codes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_RMW_END = 8'h06;
    localparam logic [7:0] CMD_RMW_BEGIN = 8'h07;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h03;
    localparam logic [7:0] CMD_ID_FIRST = 8'hda;
    localparam logic [7:0] CMD_ID_LAST = 8'hdd;

    // Values after reset
    localparam logic RST_SLEEP = 1'b1;
    localparam logic [1:0] RST_PAGE_SEL = 2'h0;
    localparam logic [6:0] RST_COL = 7'h00;
    localparam logic [3:0] RST_PAGE = 4'h0;
    localparam logic [5:0] RST_START_LINE = 6'h00;
    localparam logic [2:0] RST_BIAS = 3'h0;
    localparam logic [6:0] RST_VOP = 7'h00;
    localparam logic [2:0] RST_SCAN_RATE = 3'h0;
    localparam logic [4:0] RST_INV_SPAN = 5'h00;
    localparam logic [1:0] RST_PUMP_STRENGTH = 2'h2;
    localparam logic [1:0] RST_PUMP_STAGES = 2'h0;
    localparam logic [2:0] RST_BAND_ORIGIN = 3'h0;

    typedef enum logic [1:0] {
        PAGE_BASIC = 2'b00,
        PAGE_DISPLAY = 2'b01,
        PAGE_PARTIAL = 2'b10,
        PAGE_SYSTEM = 2'b11
    } cmd_page_type;

    typedef enum logic [1:0] {
        SHOW_BLANK = 2'b00,
        SHOW_NORMAL = 2'b01,
        SHOW_ALL_ON = 2'b10,
        SHOW_INVERSE = 2'b11
    } show_mode_type;

    typedef enum logic [1:0] {
        DUTY_FULL_68 = 2'b00,
        DUTY_PART_17 = 2'b01,
        DUTY_PART_33 = 2'b11
    } duty_type;

    typedef enum logic {
        ADDR_PLAIN = 1'b0,
        ADDR_RMW = 1'b1
    } addr_mode_type;
endpackage

/* verilog/lcd_command_decoder.sv */
/*
 Instruction decoder, configuration state, address pointers and display RAM of the LCD controller.
 Assumes the front end delivers one write or read strobe per byte, synchronous to core_clk.
*/
`timescale 1ns/1ns
module lcd_command_decoder #(
    parameter logic [7:0] ID_BYTE1 = 8'h11, // Arbitrary identification value
    parameter logic [7:0] ID_BYTE2 = 8'h22, // Arbitrary identification value
    parameter logic [7:0] ID_BYTE3 = 8'h33, // Arbitrary identification value
    parameter logic [7:0] ID_BYTE4 = 8'h44  // Arbitrary identification value
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmdOrPixelSel,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [7:0] dataIn,
    input wire logic serial3Line,
    output logic [7:0] readData,
    output logic readValid,
    output logic columnMirror,
    output logic rowFlip,
    output logic sleepBit,
    output logic analogEnable,
    output lcd_cmd_pkg::cmd_page_type cmdPageSel,
    output logic normalShowBit,
    output logic litFlag,
    output lcd_cmd_pkg::show_mode_type displayMode,
    output logic msbTop,
    output logic vlcdBand,
    output logic [2:0] biasRatioSel,
    output logic [5:0] startLine,
    output logic [6:0] driveVoltageCode,
    output logic partialEnable,
    output logic windowHeight,
    output lcd_cmd_pkg::duty_type dutySel,
    output logic [2:0] partialBandOrigin,
    output logic [2:0] scanRateCode,
    output logic [4:0] inversionSpan,
    output logic [1:0] pumpStrength,
    output logic [1:0] pumpStages,
    output logic [6:0] columnPtr,
    output logic [3:0] pagePtr,
    output logic rmwActive
);
    import lcd_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addrValid(input logic [6:0] col, input logic [3:0] page);
        addrValid = (col <= LAST_COL) && (page <= LAST_PAGE);
    endfunction

    function automatic logic [9:0] ramIndex(input logic [6:0] col, input logic [3:0] page);
        ramIndex = 10'(page) * 10'(NUM_COLS) + 10'(col);
    endfunction

    function automatic logic [6:0] colAdvance(input logic [6:0] col);
        colAdvance = (col >= LAST_COL) ? RST_COL : col + COL_STEP;
    endfunction

    function automatic show_mode_type showOf(input logic normal, input logic lit);
        showOf = show_mode_type'({lit, normal});
    endfunction

    function automatic duty_type dutyOf(input logic partial, input logic tall);
        if (!partial) begin
            dutyOf = DUTY_FULL_68;
        end else if (tall) begin
            dutyOf = DUTY_PART_33;
        end else begin
            dutyOf = DUTY_PART_17;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] ram [RAM_WORDS];
    addr_mode_type addrMode;
    logic [6:0] savedCol;
    logic [3:0] savedPage;

    logic [7:0] next_readData;
    logic next_readValid;
    logic next_columnMirror;
    logic next_rowFlip;
    logic next_sleepBit;
    cmd_page_type next_cmdPageSel;
    logic next_normalShowBit;
    logic next_litFlag;
    logic next_msbTop;
    logic next_vlcdBand;
    logic [2:0] next_biasRatioSel;
    logic [5:0] next_startLine;
    logic [6:0] next_driveVoltageCode;
    logic next_partialEnable;
    logic next_windowHeight;
    logic [2:0] next_partialBandOrigin;
    logic [2:0] next_scanRateCode;
    logic [4:0] next_inversionSpan;
    logic [1:0] next_pumpStrength;
    logic [1:0] next_pumpStages;
    logic [6:0] next_columnPtr;
    logic [3:0] next_pagePtr;
    addr_mode_type next_addrMode;
    logic [6:0] next_savedCol;
    logic [3:0] next_savedPage;
    logic ramWrite;
    logic [9:0] ramAddr;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    always_comb begin
        next_readData = readData;
        next_readValid = 1'b0;
        next_columnMirror = columnMirror;
        next_rowFlip = rowFlip;
        next_sleepBit = sleepBit;
        next_cmdPageSel = cmdPageSel;
        next_normalShowBit = normalShowBit;
        next_litFlag = litFlag;
        next_msbTop = msbTop;
        next_vlcdBand = vlcdBand;
        next_biasRatioSel = biasRatioSel;
        next_startLine = startLine;
        next_driveVoltageCode = driveVoltageCode;
        next_partialEnable = partialEnable;
        next_windowHeight = windowHeight;
        next_partialBandOrigin = partialBandOrigin;
        next_scanRateCode = scanRateCode;
        next_inversionSpan = inversionSpan;
        next_pumpStrength = pumpStrength;
        next_pumpStages = pumpStages;
        next_columnPtr = columnPtr;
        next_pagePtr = pagePtr;
        next_addrMode = addrMode;
        next_savedCol = savedCol;
        next_savedPage = savedPage;
        ramAddr = ramIndex(columnPtr, pagePtr);
        ramWrite = 1'b0;

        if (writeStrobe && cmdOrPixelSel) begin
            // Writes are taken whether or not sleep is set
            ramWrite = addrValid(columnPtr, pagePtr); // RULE_05 RULE_09
            next_columnPtr = colAdvance(columnPtr); // RULE_09 RULE_10 RULE_12
        end else if (writeStrobe) begin
            if (dataIn[7:5] == 3'b001) begin
                next_columnMirror = dataIn[4]; // RULE_01 RULE_03
                next_rowFlip = dataIn[3]; // RULE_01 RULE_03
                next_sleepBit = dataIn[2]; // RULE_01
                next_cmdPageSel = cmd_page_type'(dataIn[1:0]); // RULE_01
            end else if (dataIn != CMD_NOP) begin
                case (cmdPageSel) // RULE_02
                    PAGE_BASIC: begin
                        if (dataIn[7]) begin
                            next_columnPtr = dataIn[6:0]; // RULE_15
                        end else if (dataIn[7:4] == 4'b0100) begin
                            next_pagePtr = dataIn[3:0]; // RULE_14
                        end else if (dataIn == CMD_RMW_BEGIN) begin
                            next_addrMode = ADDR_RMW; // RULE_12
                            next_savedCol = columnPtr;
                            next_savedPage = pagePtr;
                        end else if (dataIn == CMD_RMW_END) begin
                            next_addrMode = ADDR_PLAIN; // RULE_12
                            if (addrMode == ADDR_RMW) begin
                                next_columnPtr = savedCol; // RULE_22
                                next_pagePtr = savedPage; // RULE_22
                            end
                        end else if (dataIn[7:3] == 5'b00000 && (dataIn[2] ^ dataIn[1])) begin
                            next_vlcdBand = dataIn[0]; // RULE_11
                        end else if (dataIn[7:3] == 5'b00001 && !dataIn[1]) begin
                            next_normalShowBit = dataIn[2]; // RULE_13
                            next_litFlag = dataIn[0]; // RULE_13
                        end
                    end
                    PAGE_DISPLAY: begin
                        if (dataIn[7]) begin
                            next_driveVoltageCode = dataIn[6:0]; // RULE_18
                        end else if (dataIn[7:6] == 2'b01) begin
                            next_startLine = dataIn[5:0]; // RULE_17
                        end else if (dataIn[7:3] == 5'b00010) begin
                            next_biasRatioSel = dataIn[2:0]; // RULE_16
                        end else if (dataIn[7:3] == 5'b00001) begin
                            next_msbTop = dataIn[2]; // RULE_16
                        end
                    end
                    PAGE_PARTIAL: begin
                        if (dataIn[7:1] == 7'b0000010) begin
                            next_partialEnable = dataIn[0]; // RULE_19
                        end else if (dataIn[7:1] == 7'b0000100) begin
                            next_windowHeight = dataIn[0]; // RULE_19
                        end else if (dataIn[7:3] == 5'b00010) begin
                            next_partialBandOrigin = dataIn[2:0]; // RULE_19
                        end
                    end
                    PAGE_SYSTEM: begin
                        if (dataIn == CMD_SOFT_RESET) begin
                            // Power supply settings are deliberately left alone
                            next_startLine = RST_START_LINE; // RULE_20 RULE_24
                            next_columnPtr = RST_COL; // RULE_24
                            next_pagePtr = RST_PAGE; // RULE_24
                            next_rowFlip = 1'b0; // RULE_24
                        end else if (dataIn[7:3] == 5'b00001) begin
                            next_scanRateCode = dataIn[2:0]; // RULE_20
                        end else if (dataIn[7:5] == 3'b010) begin
                            next_inversionSpan = dataIn[4:0]; // RULE_20
                        end else if (dataIn[7:4] == 4'b1001) begin
                            next_pumpStrength = dataIn[3:2]; // RULE_20
                            next_pumpStages = dataIn[1:0]; // RULE_20
                        end else if (serial3Line && dataIn >= CMD_ID_FIRST && dataIn <= CMD_ID_LAST) begin
                            next_readValid = 1'b1; // RULE_21
                            case (dataIn[1:0])
                                2'b10: next_readData = ID_BYTE1;
                                2'b11: next_readData = ID_BYTE2;
                                2'b00: next_readData = ID_BYTE3;
                                default: next_readData = ID_BYTE4;
                            endcase
                        end
                    end
                    default: begin
                        next_addrMode = addrMode; // RULE_26
                    end
                endcase
            end
        end else if (readStrobe && cmdOrPixelSel) begin
            next_readValid = 1'b1;
            next_readData = addrValid(columnPtr, pagePtr) ? ram[ramAddr] : 8'h00; // RULE_08
            if (addrMode == ADDR_PLAIN) begin
                next_columnPtr = colAdvance(columnPtr); // RULE_10 RULE_12
            end
        end else if (readStrobe) begin
            next_readValid = 1'b1;
            next_readData = {sleepBit, 2'b00, normalShowBit, litFlag, columnMirror, rowFlip, msbTop}; // RULE_06
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            readData <= 8'h00;
            readValid <= 1'b0;
            columnMirror <= 1'b0; // RULE_25
            rowFlip <= 1'b0; // RULE_25
            sleepBit <= RST_SLEEP; // RULE_25
            analogEnable <= ~RST_SLEEP;
            cmdPageSel <= cmd_page_type'(RST_PAGE_SEL); // RULE_25
            normalShowBit <= 1'b0; // RULE_25
            litFlag <= 1'b0;
            displayMode <= SHOW_BLANK;
            msbTop <= 1'b0;
            vlcdBand <= 1'b0;
            biasRatioSel <= RST_BIAS; // RULE_25
            startLine <= RST_START_LINE;
            driveVoltageCode <= RST_VOP; // RULE_25
            partialEnable <= 1'b0;
            windowHeight <= 1'b0;
            dutySel <= DUTY_FULL_68;
            partialBandOrigin <= RST_BAND_ORIGIN;
            scanRateCode <= RST_SCAN_RATE;
            inversionSpan <= RST_INV_SPAN;
            pumpStrength <= RST_PUMP_STRENGTH;
            pumpStages <= RST_PUMP_STAGES;
            columnPtr <= RST_COL; // RULE_25
            pagePtr <= RST_PAGE; // RULE_25
            rmwActive <= 1'b0;
            addrMode <= ADDR_PLAIN;
            savedCol <= RST_COL;
            savedPage <= RST_PAGE;
        end else begin
            // Fields only move through their next_ value, so they hold otherwise
            readData <= next_readData; // RULE_27
            readValid <= next_readValid;
            columnMirror <= next_columnMirror;
            rowFlip <= next_rowFlip;
            sleepBit <= next_sleepBit;
            analogEnable <= ~next_sleepBit; // RULE_04
            cmdPageSel <= next_cmdPageSel;
            normalShowBit <= next_normalShowBit;
            litFlag <= next_litFlag;
            displayMode <= showOf(next_normalShowBit, next_litFlag); // RULE_07
            msbTop <= next_msbTop;
            vlcdBand <= next_vlcdBand;
            biasRatioSel <= next_biasRatioSel;
            startLine <= next_startLine;
            driveVoltageCode <= next_driveVoltageCode;
            partialEnable <= next_partialEnable;
            windowHeight <= next_windowHeight;
            dutySel <= dutyOf(next_partialEnable, next_windowHeight); // RULE_23
            partialBandOrigin <= next_partialBandOrigin;
            scanRateCode <= next_scanRateCode;
            inversionSpan <= next_inversionSpan;
            pumpStrength <= next_pumpStrength;
            pumpStages <= next_pumpStages;
            columnPtr <= next_columnPtr;
            pagePtr <= next_pagePtr;
            rmwActive <= (next_addrMode == ADDR_RMW);
            addrMode <= next_addrMode;
            savedCol <= next_savedCol;
            savedPage <= next_savedPage;
        end
    end

    // RAM content is undefined after power-up, so it carries no reset
    always_ff @(posedge core_clk) begin
        if (ramWrite) begin
            ram[ramAddr] <= dataIn; // RULE_05 RULE_09
        end
    end
endmodule
